// ==== src/utx_pkg.sv ====
// Constants, register map and carrier types of the transmit status and
// baud-rate generator block.
// Assumes one system clock and 8-bit memory-mapped CPU accesses.
`default_nettype none

package utx_pkg;

   // ****************************************
   // Register map
   // ****************************************
   localparam logic [15:0] ADDR_TX_STATUS   = 16'hFF55;
   localparam logic [15:0] ADDR_BASE_CLK    = 16'hFF56;
   localparam logic [15:0] ADDR_BAUD_DIV    = 16'hFF57;
   localparam logic [15:0] ADDR_TX_BUFFER   = 16'hFF5A;

   localparam logic [7:0]  RST_TX_STATUS    = 8'h00;
   localparam logic [3:0]  RST_BASE_CLK     = 4'h0;
   localparam logic [7:0]  RST_BAUD_DIV     = 8'hFF;
   localparam logic [7:0]  RDATA_UNMAPPED   = 8'h00;

   localparam int          BIT_TX_BUF_FULL  = 1;
   localparam int          BIT_TX_BUSY      = 0;
   localparam int          PRESCALE_W       = 4;

   // ****************************************
   // Clock generation
   // ****************************************
   localparam logic [3:0]  PRESCALE_MAX_DIV = 4'hA;
   localparam logic [3:0]  PRESCALE_TIMER   = 4'hB;
   localparam logic [7:0]  DIVIDER_MIN      = 8'h08;
   localparam logic [1:0]  START_BASE_TICKS = 2'h2;

   // ****************************************
   // Frame
   // ****************************************
   localparam logic [3:0]  FRAME_BITS       = 4'hA;
   localparam logic        LINE_IDLE        = 1'b1;
   localparam logic        LINE_START       = 1'b0;

   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } utx_cpu_req_s;

   typedef struct packed {
      logic power;
      logic tx_en;
      logic rx_en;
   } utx_mode_s;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_SEND = 2'b10
   } utx_tx_state_e;

endpackage

`default_nettype wire

// ==== src/utx_fifo.sv ====
// Synchronous FIFO holding bytes waiting for the transmit shift register.
// Assumes one clock; flush empties it in one cycle.
`default_nettype none

module utx_fifo
   import utx_pkg::*;
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   input  wire logic             flush,
   input  wire logic             in_valid,
   output var  logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);

   localparam int PW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_chk
      $error("utx_fifo: DEPTH must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PW-1:0]    wr_ptr_r;
   logic [PW-1:0]    rd_ptr_r;
   logic [PW:0]      count_r;
   logic [PW:0]      count_nxt;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   assign out_valid = (count_r != '0);
   assign out_data  = mem_r[rd_ptr_r];
   assign count_nxt = flush ? '0 :
                      (count_r + (PW+1)'(push) - (PW+1)'(pop));

   // Ready is registered so the source sees a clean flop output.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
         in_ready <= 1'b1;
      end else begin
         wr_ptr_r <= flush ? '0 : wr_ptr_r + PW'(push);
         rd_ptr_r <= flush ? '0 : rd_ptr_r + PW'(pop);
         count_r  <= count_nxt;
         in_ready <= (count_nxt != (PW+1)'(DEPTH));
      end
   end

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

endmodule

`default_nettype wire

// ==== src/utx_core.sv ====
// Transmit status flags, base-clock prescaler, 8-bit baud divider and a
// simple 8N1 transmitter fed by a byte FIFO.
// Assumes CPU strobes and mode bits synchronous to clk_sys, one access
// per cycle, and a timer output already synchronous to clk_sys.
`default_nettype none

// Behaviour
// - A buffer write sets the buffer-occupied flag.
// - Buffer flag clears when power or transmit enable is 0, or when the last queued byte transfers.
// - Busy flag sets when a byte moves into the shift register.
// - Busy clears when disabled, or frame ends with no new byte.
// - After transfer a new write follows the frame without gap.
// - Status register is read-only, 00H after reset and while disabled.
// - Select code 0..10 divides system clock by 2^code; 11 picks timer.
// - Divider divides base clock by k, valid 8..255.
// - Baud rate equals the divider output clock, base clock divided by 2k.
// - Rewriting select or divider with same value leaves traffic intact.
// - Reset loads divider with FFH and select with 00H.
// - Power off stops and holds the clock low and clears the logic.
// - Divider starts counting on the third base clock after power on; the first two are skipped.
module utx_core
   import utx_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic         clk_sys,
   input  wire logic         sys_rst,
   input  wire utx_cpu_req_s cpu_req,
   output var  logic [7:0]   cpu_rdata,
   output var  logic         tx_wr_ready,
   input  wire utx_mode_s    mode,
   input  wire logic         timer_output_source,
   output var  logic         txd,
   output var  logic         baud_clk,
   output var  logic         tx_done
);

   if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk
      $error("utx_core: FIFO_DEPTH must be a power of two of at least 2");
   end

   // ****************************************
   // Decoding
   // ****************************************
   function automatic logic hit(input utx_cpu_req_s r,
                                input logic [15:0] a);
      hit = (r.addr == a);
   endfunction

   function automatic logic presc_tick(input logic [3:0] code,
                                       input logic [9:0] cnt,
                                       input logic       tmr_rise);
      logic [9:0] mask;
      mask = 10'h000;
      if (code == PRESCALE_TIMER) begin
         presc_tick = tmr_rise;
      end else if (code > PRESCALE_MAX_DIV) begin
         presc_tick = 1'b0;
      end else begin
         mask = 10'((11'h001 << code) - 11'h001);
         presc_tick = ((cnt & mask) == mask);
      end
   endfunction

   wire logic iface_on = mode.power;
   wire logic tx_on    = mode.power && mode.tx_en;
   wire logic wr_stat  = cpu_req.wr && hit(cpu_req, ADDR_TX_STATUS);
   wire logic wr_base  = cpu_req.wr && hit(cpu_req, ADDR_BASE_CLK);
   wire logic wr_div   = cpu_req.wr && hit(cpu_req, ADDR_BAUD_DIV);
   wire logic wr_txbuf = cpu_req.wr && hit(cpu_req, ADDR_TX_BUFFER);

   // ****************************************
   // Registers
   // ****************************************
   logic [3:0] base_sel_r;
   logic [7:0] baud_div_r;

   // Writes store unconditionally; an equal value changes nothing, so a
   // refresh during traffic leaves the counters alone.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         base_sel_r <= RST_BASE_CLK;
         baud_div_r <= RST_BAUD_DIV;
      end else begin
         if (wr_base) begin
            base_sel_r <= cpu_req.wdata[PRESCALE_W-1:0];
         end
         if (wr_div) begin
            baud_div_r <= cpu_req.wdata;
         end
      end
   end

   // ****************************************
   // Base clock prescaler
   // ****************************************
   logic [9:0] pre_cnt_r;
   logic       tmr_prev_r;
   wire logic  tmr_rise  = timer_output_source && !tmr_prev_r;
   wire logic  base_tick = iface_on &&
                           presc_tick(base_sel_r, pre_cnt_r, tmr_rise);

   // Power off freezes and zeroes the prescaler, so no base tick leaks.
   always_ff @(posedge clk_sys) begin
      if (sys_rst || !iface_on) begin
         pre_cnt_r  <= 10'h000;
      end else begin
         pre_cnt_r  <= pre_cnt_r + 10'h001;
      end
   end

   // The edge detector tracks the timer even with power off and leaves
   // reset high, so a timer already high gives no false first tick.
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         tmr_prev_r <= 1'b1;
      end else begin
         tmr_prev_r <= timer_output_source;
      end
   end

   // ****************************************
   // Baud divider
   // ****************************************
   logic [1:0] start_cnt_r;
   logic [7:0] div_cnt_r;
   logic       div_out_r;

   // Prohibited small divisors are served as the least legal one, which
   // keeps the frame timing finite instead of spinning.
   wire logic [7:0] div_k    = (baud_div_r < DIVIDER_MIN) ?
                               DIVIDER_MIN : baud_div_r;
   wire logic       div_run  = (start_cnt_r == START_BASE_TICKS);
   wire logic       div_wrap = base_tick && div_run &&
                               (div_cnt_r == div_k - 8'h01);
   // One bit time is two half periods of the divider output.
   wire logic       bit_tick = div_wrap && div_out_r;

   always_ff @(posedge clk_sys) begin
      if (sys_rst || !iface_on) begin
         start_cnt_r <= 2'h0;
         div_cnt_r   <= 8'h00;
         div_out_r   <= 1'b0;
      end else begin
         if (base_tick && !div_run) begin
            start_cnt_r <= start_cnt_r + 2'h1;
         end
         if (div_wrap) begin
            div_cnt_r <= 8'h00;
            div_out_r <= !div_out_r;
         end else if (base_tick && div_run) begin
            div_cnt_r <= div_cnt_r + 8'h01;
         end
      end
   end

   // ****************************************
   // Transmit buffer
   // ****************************************
   logic       q_valid;
   logic [7:0] q_data;
   logic       q_pop;
   logic       q_in_ready;

   // Writes while disabled or while the queue is full are dropped; the
   // ready output lets a host avoid the loss instead of polling.
   utx_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .sys_rst   (sys_rst),
      .flush     (!tx_on),
      .in_valid  (wr_txbuf && tx_on),
      .in_ready  (q_in_ready),
      .in_data   (cpu_req.wdata),
      .out_valid (q_valid),
      .out_ready (q_pop),
      .out_data  (q_data)
   );

   // ****************************************
   // Transmitter
   // ****************************************
   utx_tx_state_e state_r;
   utx_tx_state_e state_nxt;
   logic [9:0]    shift_r;
   logic [3:0]    bit_cnt_r;
   logic          busy_r;
   logic          done_r;
   logic          txd_r;

   wire logic last_bit = (bit_cnt_r == FRAME_BITS - 4'h1);
   wire logic frame_end = (state_r == TX_SEND) && bit_tick && last_bit;
   // A queued byte loads on the bit edge that ends the frame, so the
   // next start bit follows the stop bit directly.
   wire logic load = tx_on && q_valid && bit_tick &&
                     ((state_r == TX_IDLE) || last_bit);
   wire logic [9:0] frame = {LINE_IDLE, q_data, LINE_START};

   assign q_pop = load;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         TX_IDLE: begin
            if (load) begin
               state_nxt = TX_SEND;
            end
         end
         TX_SEND: begin
            if (frame_end && !load) begin
               state_nxt = TX_IDLE;
            end
         end
         default: begin
            state_nxt = TX_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst || !tx_on) begin
         state_r <= TX_IDLE;
         done_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         done_r  <= frame_end;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst || !tx_on) begin
         busy_r <= 1'b0;
      end else if (load) begin
         busy_r <= 1'b1;
      end else if (frame_end) begin
         busy_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst || !tx_on) begin
         shift_r   <= {10{LINE_IDLE}};
         bit_cnt_r <= 4'h0;
      end else if (load) begin
         shift_r   <= frame;
         bit_cnt_r <= 4'h0;
      end else if ((state_r == TX_SEND) && bit_tick && !last_bit) begin
         shift_r   <= {LINE_IDLE, shift_r[9:1]};
         bit_cnt_r <= bit_cnt_r + 4'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst || !tx_on) begin
         txd_r <= LINE_IDLE;
      end else if (load) begin
         txd_r <= LINE_START;
      end else if (frame_end) begin
         txd_r <= LINE_IDLE;
      end else if ((state_r == TX_SEND) && bit_tick) begin
         txd_r <= shift_r[1];
      end
   end

   // ****************************************
   // Read port
   // ****************************************
   // The status word has no storage of its own; it is the live flags,
   // which the disable path above already forces to zero.
   logic [7:0] status_word;
   logic [7:0] rdata_sel;

   always_comb begin
      status_word = RST_TX_STATUS;
      status_word[BIT_TX_BUF_FULL] = q_valid;
      status_word[BIT_TX_BUSY]     = busy_r;
      if (hit(cpu_req, ADDR_TX_STATUS)) begin
         rdata_sel = status_word;
      end else if (hit(cpu_req, ADDR_BASE_CLK)) begin
         rdata_sel = {4'h0, base_sel_r};
      end else if (hit(cpu_req, ADDR_BAUD_DIV)) begin
         rdata_sel = baud_div_r;
      end else begin
         rdata_sel = RDATA_UNMAPPED;
      end
   end

   // A write to the status address stores nothing; it only blocks the read data update that cycle.
   wire logic stat_write_ignored = wr_stat;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         cpu_rdata <= RDATA_UNMAPPED;
      end else if (cpu_req.rd && !stat_write_ignored) begin
         cpu_rdata <= rdata_sel;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         tx_wr_ready <= 1'b0;
      end else begin
         tx_wr_ready <= q_in_ready && tx_on;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         txd <= LINE_IDLE;
      end else begin
         txd <= txd_r;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         baud_clk <= 1'b0;
      end else begin
         baud_clk <= div_out_r;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         tx_done <= 1'b0;
      end else begin
         tx_done <= done_r;
      end
   end

endmodule

`default_nettype wire

// ==== dv/utx_core_assertions.sv ====
// Port checker of the transmit status and baud generator block.
// Assumes it is bound to utx_core and sees only that module's ports.
`default_nettype none

module utx_core_assertions
   import utx_pkg::*;
(
   input wire logic         clk_sys,
   input wire logic         sys_rst,
   input wire utx_cpu_req_s cpu_req,
   input wire logic [7:0]   cpu_rdata,
   input wire logic         tx_wr_ready,
   input wire utx_mode_s    mode,
   input wire logic         timer_output_source,
   input wire logic         txd,
   input wire logic         baud_clk,
   input wire logic         tx_done
);
   timeunit 1ns;
   timeprecision 1ps;

   wire logic on = mode.power && mode.tx_en;
   wire logic rd_ok = cpu_req.rd && !cpu_req.wr;
   wire logic rd_st = rd_ok && cpu_req.addr == ADDR_TX_STATUS;
   wire logic rd_sel = rd_ok && cpu_req.addr == ADDR_BASE_CLK;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   property p_st_off; (!on)[*2] ##0 rd_st |=> cpu_rdata == 8'h00; endproperty
   a_st_off: assert property (p_st_off)
      else $error("status not clear while disabled");
   property p_st_hi; rd_st |=> cpu_rdata[7:2] == 6'h00; endproperty
   a_st_hi: assert property (p_st_hi)
      else $error("status upper bits set");
   property p_sel_hi; rd_sel |=> cpu_rdata[7:4] == 4'h0; endproperty
   a_sel_hi: assert property (p_sel_hi)
      else $error("select upper bits set");
   property p_idle; (!mode.power)[*3] |-> txd && !baud_clk; endproperty
   a_idle: assert property (p_idle)
      else $error("line or divider active with power off");
   property p_ready; (!on)[*3] |-> !tx_wr_ready; endproperty
   a_ready: assert property (p_ready)
      else $error("buffer ready while disabled");
   property p_wake; $rose(mode.power) && !baud_clk |=> (!baud_clk)[*7];
   endproperty
   a_wake: assert property (p_wake)
      else $error("divider output too early after power on");
   property p_half;
      $changed(baud_clk) && mode.power |=>
         (!mode.power || $stable(baud_clk))[*7];
   endproperty
   a_half: assert property (p_half)
      else $error("half baud period under eight ticks");
   property p_start; $fell(txd) |=> (!txd || !on)[*8]; endproperty
   a_start: assert property (p_start)
      else $error("start bit too short");
   property p_done; tx_done |=> !tx_done; endproperty
   a_done: assert property (p_done)
      else $error("frame done longer than one cycle");
endmodule

`default_nettype wire

// ==== dv/utx_line_rx.sv ====
// Remote receiver model: decodes 8N1 frames seen on the serial line.
// Assumes a fixed bit length in system clock cycles, idle-high line.
`default_nettype none

module utx_line_rx #(
   parameter int BIT_CYC = 16
) (
   input  wire logic       clk_sys,
   input  wire logic       txd,
   output var  logic [7:0] rx_byte,
   output var  logic       rx_stb,
   output var  logic       rx_stop
);
   timeunit 1ns;
   timeprecision 1ps;

   // Sampling on the falling edge keeps clear of the launching edge.
   initial begin
      rx_byte = 8'h00;
      rx_stb = 1'b0;
      rx_stop = 1'b0;
      forever begin
         @(negedge txd);
         repeat (BIT_CYC / 2) @(negedge clk_sys);
         for (int i = 0; i < 9; i++) begin
            repeat (BIT_CYC) @(negedge clk_sys);
            if (i < 8) rx_byte[i] = txd;
            else rx_stop = txd;
         end
         rx_stb = 1'b1;
         @(negedge clk_sys);
         rx_stb = 1'b0;
      end
   end
endmodule

`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench of the transmit status and baud generator.
// Assumes utx_core with a line receiver model on its serial output.
`default_nettype none

module testbench
   import utx_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic         clk_sys = 1'b0;
   logic         sys_rst = 1'b1;
   utx_cpu_req_s cpu_req = '0;
   utx_mode_s    mode = '0;
   logic         tmr = 1'b0;
   logic [7:0]   cpu_rdata, rx_byte;
   logic         tx_wr_ready, txd, baud_clk, tx_done, rx_stb, rx_stop;
   int           error_cnt = 0;
   int           tests_run = 0;
   int           done_cnt = 0;
   int           cyc = 0;
   time          t0;
   logic [7:0]   exp_q[$], got_q[$];
   time          got_t[$];
   logic [31:0]  tbl [6][3] = '{'{0, 8, 16}, '{1, 8, 32}, '{0, 9, 18},
                              '{11, 8, 64}, '{2, 10, 80}, '{0, 5, 16}};

   utx_core #(.FIFO_DEPTH(16)) u_utx_core (.clk_sys, .sys_rst, .cpu_req,
      .cpu_rdata, .tx_wr_ready, .mode, .timer_output_source(tmr), .txd,
      .baud_clk, .tx_done);
   utx_line_rx #(.BIT_CYC(16)) u_utx_line_rx (.clk_sys, .txd, .rx_byte,
      .rx_stb, .rx_stop);

   initial forever #10 clk_sys = ~clk_sys;
   // The timer runs from time zero, so it is started before selection.
   initial forever begin
      repeat (2) @(posedge clk_sys);
      #1 tmr = ~tmr;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("Checks %0d, errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic acc(input logic w, input logic [15:0] a,
                      input logic [7:0] d);
      @(posedge clk_sys);
      #1 cpu_req = '{a, d, w, !w};
      @(posedge clk_sys);
      #1 cpu_req.wr = 1'b0;
      cpu_req.rd = 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      acc(1'b0, a, 8'h00);
      chk(cpu_rdata, e);
   endtask

   task automatic poll(input logic [7:0] e);
      int n;
      n = 0;
      do begin
         acc(1'b0, ADDR_TX_STATUS, 8'h00);
         n++;
      end while (cpu_rdata !== e && n < 2000);
      chk(cpu_rdata, e);
   endtask

   task automatic set_mode(input logic p, input logic t);
      @(posedge clk_sys);
      #1 mode = '{p, t, 1'b0};
   endtask

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 30000) begin
         error_cnt++;
         end_of_test();
      end
   end

   always @(posedge rx_stb) begin
      got_q.push_back(rx_byte);
      got_t.push_back($time);
      chk(rx_stop, 1'b1);
   end

   // Counted on the falling edge, where the one-cycle pulse is settled.
   always @(negedge clk_sys) begin
      if (tx_done === 1'b1) done_cnt++;
   end

   initial begin
      repeat (2) @(posedge clk_sys);
      #1 sys_rst = 1'b0;
      foreach (tbl[r]) begin
         set_mode(1'b0, 1'b0);
         acc(1'b1, ADDR_BASE_CLK, tbl[r][0][7:0]);
         acc(1'b1, ADDR_BAUD_DIV, tbl[r][1][7:0]);
         rd(ADDR_BASE_CLK, tbl[r][0][7:0]);
         rd(ADDR_BAUD_DIV, tbl[r][1][7:0]);
         set_mode(1'b1, 1'b0);
         @(posedge baud_clk);
         t0 = $time;
         @(posedge baud_clk);
         chk(32'(($time - t0) / 20), tbl[r][2]);
      end
      // A prohibited select code gives no base clock, so the divider rests.
      set_mode(1'b0, 1'b0);
      acc(1'b1, ADDR_BASE_CLK, 8'h0C);
      set_mode(1'b1, 1'b0);
      repeat (40) @(posedge clk_sys);
      #1 chk(baud_clk, 1'b0);
      // A second reset in mid-run must bring back the defaults.
      @(posedge clk_sys);
      #1 sys_rst = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 sys_rst = 1'b0;
      rd(ADDR_TX_STATUS, 8'h00);
      rd(ADDR_BASE_CLK, 8'h00);
      rd(ADDR_BAUD_DIV, 8'hFF);
      acc(1'b1, ADDR_TX_STATUS, 8'hFF);
      rd(ADDR_TX_STATUS, 8'h00);
      rd(16'h1234, 8'h00);
      set_mode(1'b0, 1'b0);
      acc(1'b1, ADDR_BAUD_DIV, 8'h08);
      set_mode(1'b1, 1'b1);
      repeat (4) @(posedge clk_sys);
      for (int i = 0; i < 24; i++) begin
         if (tx_wr_ready === 1'b1) begin
            exp_q.push_back(8'(i * 37 + 5));
            acc(1'b1, ADDR_TX_BUFFER, exp_q[$]);
         end
         if (i == 0) poll(8'h01);
         if (i == 1) rd(ADDR_TX_STATUS, 8'h03);
         repeat (2) @(posedge clk_sys);
         #1;
      end
      chk(tx_wr_ready, 1'b0);
      acc(1'b1, ADDR_BASE_CLK, 8'h00);
      acc(1'b1, ADDR_BAUD_DIV, 8'h08);
      poll(8'h00);
      repeat (20) @(posedge clk_sys);
      chk(got_q.size(), exp_q.size());
      chk(done_cnt, exp_q.size());
      foreach (exp_q[i]) begin
         chk(got_q[i], exp_q[i]);
         if (i > 0) chk(32'((got_t[i] - got_t[i-1]) / 20), 160);
      end
      acc(1'b1, ADDR_TX_BUFFER, 8'h5A);
      poll(8'h01);
      acc(1'b1, ADDR_TX_BUFFER, 8'hC3);
      rd(ADDR_TX_STATUS, 8'h03);
      set_mode(1'b1, 1'b0);
      rd(ADDR_TX_STATUS, 8'h00);
      set_mode(1'b1, 1'b1);
      rd(ADDR_TX_STATUS, 8'h00);
      chk(txd, 1'b1);
      end_of_test();
   end
endmodule

bind utx_core utx_core_assertions u_chk (.clk_sys, .sys_rst, .cpu_req,
   .cpu_rdata, .tx_wr_ready, .mode, .timer_output_source, .txd,
   .baud_clk, .tx_done);

`default_nettype wire
